// ---- include/seq_pkg.sv ----
// Shared constants, types and helpers for the start-up and soft-start sequencer.
//
// Behaviour
// - On power-up run memory check, then strap sampling, then enter ready.
// - The memory check lasts roughly five to ten milliseconds.
// - Ignore enable and bus traffic during memory check and strap sampling.
// - Load previously stored user settings during the memory check.
// - After the memory step sample every strap and apply its settings.
// - A Restore command repeats the memory check.
// - Accept bus commands and act on enable only once initialisation ends.
// - Wait at least 2 ms after enable; shorter delays become 2 ms.
// - Delays above 2 ms are waited in full from the enable; a 255 ms delay in normal mode wraps to no wait.
// - After the delay, ramp the output over the selected ramp time.
// - Enable held high from power-up still waits for initialisation.
// - Delay timing starts at enable and ends when the delay has elapsed.
// - Precise delay timing applies only when its configuration bit is set.
// - The output ramp counts up and steps backward only when a target lowered mid-ramp pulls the reference down.
// - Two three-level delay straps select 0 to 200 ms.
// - With 0 or 1 ms selected, ramp starts after the 2 ms minimum wait from enable.
// - Alternate trim mode maps the coarse trim resistor to a target voltage.
// - Ramp strap LOW, OPEN, HIGH selects 0, 5 or 10 ms.
// - Strap values are taken only at start-up or Restore and then held.
package seq_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned MS_PER_S = 1000;
   localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
   localparam logic [7:0] NVM_CHECK_MS = 8'h05;
   localparam logic [7:0] PRE_RAMP_MIN_MS = 8'h02;

   // ---------------------------------------------------------------
   // Register map (byte addresses) and fields
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_DELAY = 8'h04;
   localparam logic [7:0] ADDR_RAMP = 8'h08;
   localparam logic [7:0] ADDR_TARGET = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam int CTRL_RESTORE = 0;
   localparam int CTRL_PRECISE = 1;
   localparam int CTRL_DLY_BUS = 2;
   localparam int CTRL_RAMP_BUS = 3;
   localparam int STAT_VOUT_LSB = 16;
   localparam logic [12:0] TARGET_RST_MV = 13'h0_3E8;

   // ---------------------------------------------------------------
   // Three-level strap codes
   // ---------------------------------------------------------------
   localparam logic [1:0] STRAP_LOW = 2'h0;
   localparam logic [1:0] STRAP_OPEN = 2'h1;
   localparam logic [1:0] STRAP_HIGH = 2'h2;
   localparam logic [7:0] RAMP_LOW_MS = 8'h00;
   localparam logic [7:0] RAMP_OPEN_MS = 8'h05;
   localparam logic [7:0] RAMP_HIGH_MS = 8'h0A;

   // Delay table, row = high digit, column = low digit.
   localparam logic [7:0] DLY_TABLE [9] = '{
      8'h00, 8'h01, 8'h02, 8'h05, 8'h0A, 8'h14, 8'h32, 8'h64, 8'hC8};

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_CHECK, ST_PINS, ST_READY, ST_DELAY, ST_RAMP, ST_ON
   } seq_state_e;

   typedef struct packed {
      logic [1:0] delay_strap_high_digit;
      logic [1:0] delay_strap_low_digit;
      logic [1:0] ramp_strap;
      logic alliance_trim_mapping;
      logic [4:0] coarse_trim_resistor;
   } strap_s;

   typedef struct packed {
      logic stored;
      logic [7:0] delay_ms;
      logic [7:0] ramp_ms;
      logic [12:0] target_mv;
   } nvm_s;

   // Strap level to table index; an illegal code reads as HIGH.
   function automatic logic [3:0] strap_idx(input logic [1:0] lvl);
      return (lvl == STRAP_LOW) ? 4'h0 : (lvl == STRAP_OPEN) ? 4'h1 : 4'h2;
   endfunction : strap_idx

   function automatic logic [7:0] dly_decode(input logic [1:0] hi, input logic [1:0] lo);
      logic [3:0] idx;
      idx = 4'((strap_idx(hi) * 4'h3) + strap_idx(lo));
      return DLY_TABLE[idx];
   endfunction : dly_decode

   function automatic logic [7:0] ramp_decode(input logic [1:0] lvl);
      return (lvl == STRAP_LOW) ? RAMP_LOW_MS :
             (lvl == STRAP_OPEN) ? RAMP_OPEN_MS : RAMP_HIGH_MS;
   endfunction : ramp_decode

endpackage : seq_pkg

// ---- hw/trim_target_rom.sv ----
// Lookup memory from coarse trim resistor index to output target in millivolts.
module trim_target_rom (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [4:0] addr,
   output logic [12:0] data_q
);

   // ---------------------------------------------------------------
   // Table, ordered from the largest resistor to the smallest
   // ---------------------------------------------------------------
   logic [12:0] rom_d;

   // Unused indices clamp to the highest target so a bad strap is obvious.
   always_comb begin
      case (addr)
         5'h00: rom_d = 13'h0_2BC;
         5'h01: rom_d = 13'h0_2F0;
         5'h02: rom_d = 13'h0_2F6;
         5'h03: rom_d = 13'h0_2FD;
         5'h04: rom_d = 13'h0_304;
         5'h05: rom_d = 13'h0_316;
         5'h06: rom_d = 13'h0_320;
         5'h07: rom_d = 13'h0_335;
         5'h08: rom_d = 13'h0_342;
         5'h09: rom_d = 13'h0_350;
         5'h0A: rom_d = 13'h0_370;
         5'h0B: rom_d = 13'h0_383;
         5'h0C: rom_d = 13'h0_397;
         5'h0D: rom_d = 13'h0_3C5;
         5'h0E: rom_d = 13'h0_3DF;
         5'h0F: rom_d = 13'h0_3E8;
         5'h10: rom_d = 13'h0_44C;
         5'h11: rom_d = 13'h0_486;
         5'h12: rom_d = 13'h0_4B0;
         5'h13: rom_d = 13'h0_4E2;
         5'h14: rom_d = 13'h0_5DC;
         5'h15: rom_d = 13'h0_685;
         5'h16: rom_d = 13'h0_708;
         5'h17: rom_d = 13'h0_8F7;
         5'h18: rom_d = 13'h0_9CA;
         5'h19: rom_d = 13'h0_CE4;
         default: rom_d = 13'h1_388;
      endcase
   end

   // Registered read port.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         data_q <= 13'h0_000;
      end else begin
         data_q <= rom_d;
      end
   end

endmodule : trim_target_rom

// ---- hw/startup_softstart_sequencer.sv ----
// Power-up, memory check, strap sampling, pre-ramp delay and soft-start ramp.
module startup_softstart_sequencer #(
   parameter int unsigned CYC_PER_MS = seq_pkg::MS_CYCLES
) (
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic EN,
   input wire seq_pkg::strap_s STRAPS,
   input wire seq_pkg::nvm_s NVM,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic READY,
   output logic RAMPING,
   output logic OUTPUT_ON,
   output logic [12:0] VOUT_REF_MV
);
   import seq_pkg::*;

   localparam int PRE_W = $clog2(CYC_PER_MS);

   seq_state_e state_q;
   logic [PRE_W-1:0] pre_q;
   logic ms_tick_q;
   logic [7:0] ms_cnt_q;
   logic [7:0] dly_goal_q;
   logic precise_q;
   logic dly_bus_q;
   logic ramp_bus_q;
   logic [7:0] bus_dly_q;
   logic [7:0] bus_ramp_q;
   logic [12:0] bus_target_q;
   logic [7:0] pin_dly_q;
   logic [7:0] pin_ramp_q;
   logic pin_alt_q;
   logic [12:0] pin_target_q;
   logic [12:0] rom_data;
   logic [15:0] err_q;
   logic [12:0] vout_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic busy;
   logic access;
   logic wr_ok;
   logic restore;
   logic start;
   logic [7:0] dly_cfg;
   logic [7:0] ramp_cfg;
   logic [12:0] target;
   logic [7:0] dly_wait;
   logic addr_hit;

   // ---------------------------------------------------------------
   // Configuration selection
   // ---------------------------------------------------------------

   // Bus or stored settings override the strap delay and ramp when selected.
   assign dly_cfg = dly_bus_q ? bus_dly_q : pin_dly_q;
   assign ramp_cfg = ramp_bus_q ? bus_ramp_q : pin_ramp_q;
   assign target = pin_alt_q ? pin_target_q : bus_target_q;
   // Short settings are raised to the floor.
   assign dly_wait = (dly_cfg < PRE_RAMP_MIN_MS) ? PRE_RAMP_MIN_MS : dly_cfg;

   // Busy covers the memory check and strap sampling steps.
   assign busy = (state_q == ST_CHECK) || (state_q == ST_PINS);
   // Enable acts only from ready, so an early enable leaves no trace.
   assign start = (state_q == ST_READY) && EN;

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------

   // An access phase is answered one cycle after it starts.
   assign access = PSEL && PENABLE && !pready_q;
   assign addr_hit = (PADDR == ADDR_CTRL) || (PADDR == ADDR_DELAY) ||
                     (PADDR == ADDR_RAMP) || (PADDR == ADDR_TARGET) ||
                     (PADDR == ADDR_STATUS);
   // A write lands at the edge that samples the answer, and only if it was not refused.
   assign wr_ok = PSEL && PENABLE && pready_q && !pslverr_q && PWRITE && !busy;
   assign restore = wr_ok && (PADDR == ADDR_CTRL) && PWDATA[CTRL_RESTORE];

   // ---------------------------------------------------------------
   // Millisecond timebase
   // ---------------------------------------------------------------

   // In precise mode the prescaler restarts at enable, so the delay is exact
   // instead of carrying up to one millisecond of phase uncertainty.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         pre_q <= '0;
      end else if ((start && precise_q) || (pre_q == PRE_W'(CYC_PER_MS - 1))) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + 1'b1;
      end
   end

   // One-cycle tick at the end of each millisecond.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         ms_tick_q <= 1'b0;
      end else begin
         ms_tick_q <= (pre_q == PRE_W'(CYC_PER_MS - 1)) && !(start && precise_q);
      end
   end

   // Milliseconds spent in the current step, cleared on Restore, at enable and during strap sampling.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         ms_cnt_q <= '0;
      end else if (restore || start || (state_q == ST_PINS)) begin
         ms_cnt_q <= '0;
      end else if (ms_tick_q && (ms_cnt_q != 8'hFF)) begin
         ms_cnt_q <= ms_cnt_q + 1'b1;
      end
   end

   // Delay goal latched at enable; normal mode adds one tick to cover the
   // partial first millisecond; the wait is never short except at 255 ms, where the goal wraps to 0.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         dly_goal_q <= PRE_RAMP_MIN_MS;
      end else if (start) begin
         dly_goal_q <= precise_q ? dly_wait : 8'(dly_wait + 1'b1);
      end
   end

   // ---------------------------------------------------------------
   // Sequence state
   // ---------------------------------------------------------------

   // Restore restarts the memory check from any ready-side state.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_q <= ST_CHECK;
      end else if (restore) begin
         state_q <= ST_CHECK;
      end else begin
         case (state_q)
            ST_CHECK: begin
               if (ms_tick_q && (ms_cnt_q >= NVM_CHECK_MS)) begin
                  state_q <= ST_PINS;
               end
            end
            ST_PINS: state_q <= ST_READY;
            ST_READY: begin
               if (EN) begin
                  state_q <= ST_DELAY;
               end
            end
            ST_DELAY: begin
               if (!EN) begin
                  state_q <= ST_READY;
               end else if (ms_cnt_q >= dly_goal_q) begin
                  state_q <= ST_RAMP;
               end
            end
            ST_RAMP: begin
               if (!EN) begin
                  state_q <= ST_READY;
               end else if ((ramp_cfg == RAMP_LOW_MS) || (vout_q >= target)) begin
                  state_q <= ST_ON;
               end
            end
            ST_ON: begin
               if (!EN) begin
                  state_q <= ST_READY;
               end
            end
            default: state_q <= ST_CHECK;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Strap capture
   // ---------------------------------------------------------------

   trim_target_rom u_rom (
      .clk (REF_CLK),
      .rst_b (RST_B),
      .addr (STRAPS.coarse_trim_resistor),
      .data_q (rom_data)
   );

   // Straps are read once per start-up or Restore and then held, so a
   // resistor changed later has no effect.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         pin_dly_q <= '0;
         pin_ramp_q <= '0;
         pin_alt_q <= 1'b0;
         pin_target_q <= '0;
      end else if (state_q == ST_PINS) begin
         pin_dly_q <= dly_decode(STRAPS.delay_strap_high_digit,
                                 STRAPS.delay_strap_low_digit);
         pin_ramp_q <= ramp_decode(STRAPS.ramp_strap);
         pin_alt_q <= STRAPS.alliance_trim_mapping;
         pin_target_q <= rom_data;
      end
   end

   // ---------------------------------------------------------------
   // Software settings
   // ---------------------------------------------------------------

   // Stored settings are loaded at the end of the check; bus writes are
   // impossible then, so the two never collide.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         precise_q <= 1'b0;
         dly_bus_q <= 1'b0;
         ramp_bus_q <= 1'b0;
         bus_dly_q <= '0;
         bus_ramp_q <= '0;
         bus_target_q <= TARGET_RST_MV;
      end else if ((state_q == ST_CHECK) && ms_tick_q &&
                   (ms_cnt_q >= NVM_CHECK_MS) && NVM.stored) begin
         dly_bus_q <= 1'b1;
         ramp_bus_q <= 1'b1;
         bus_dly_q <= NVM.delay_ms;
         bus_ramp_q <= NVM.ramp_ms;
         bus_target_q <= NVM.target_mv;
      end else if (wr_ok) begin
         case (PADDR)
            ADDR_CTRL: begin
               precise_q <= PWDATA[CTRL_PRECISE];
               dly_bus_q <= PWDATA[CTRL_DLY_BUS];
               ramp_bus_q <= PWDATA[CTRL_RAMP_BUS];
            end
            ADDR_DELAY: bus_dly_q <= PWDATA[7:0];
            ADDR_RAMP: bus_ramp_q <= PWDATA[7:0];
            ADDR_TARGET: bus_target_q <= PWDATA[12:0];
            default: bus_dly_q <= bus_dly_q;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Soft-start ramp
   // ---------------------------------------------------------------

   // Error accumulator: each millisecond adds the target, each step of one
   // millivolt removes the ramp length, so the slope is target over ramp.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         err_q <= '0;
      end else if (state_q != ST_RAMP) begin
         err_q <= '0;
      end else if (err_q >= {8'h00, ramp_cfg}) begin
         err_q <= err_q - {8'h00, ramp_cfg};
      end else if (ms_tick_q) begin
         err_q <= err_q + {3'h0, target};
      end
   end

   // The reference counts up during the ramp and is clamped at the target, so it
   // cannot overshoot; it steps back only if the target is lowered mid-ramp.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         vout_q <= '0;
      end else begin
         case (state_q)
            ST_RAMP: begin
               if ((ramp_cfg == RAMP_LOW_MS) || (vout_q >= target)) begin
                  vout_q <= target;
               end else if ((err_q >= {8'h00, ramp_cfg}) && !restore) begin
                  vout_q <= vout_q + 1'b1;
               end
            end
            ST_ON: vout_q <= restore ? '0 : target;
            default: vout_q <= '0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // APB response
   // ---------------------------------------------------------------

   // Unmapped addresses and any access during initialisation get an error.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= access;
         pslverr_q <= access && (busy || !addr_hit);
      end
   end

   // Read data; restore reads back as zero since it is a pulse.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         prdata_q <= '0;
      end else if (access && !PWRITE && !busy) begin
         case (PADDR)
            ADDR_CTRL: prdata_q <= {28'h000_0000, ramp_bus_q, dly_bus_q, precise_q, 1'b0};
            ADDR_DELAY: prdata_q <= {24'h00_0000, bus_dly_q};
            ADDR_RAMP: prdata_q <= {24'h00_0000, bus_ramp_q};
            ADDR_TARGET: prdata_q <= {19'h0_0000, target};
            ADDR_STATUS: prdata_q <= {3'h0, vout_q, 13'h0_000, state_q};
            default: prdata_q <= '0;
         endcase
      end else begin
         prdata_q <= '0;
      end
   end

   // ---------------------------------------------------------------
   // Status outputs
   // ---------------------------------------------------------------

   // Status flags are registered copies of the current state decode.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         READY <= 1'b0;
         RAMPING <= 1'b0;
         OUTPUT_ON <= 1'b0;
      end else begin
         READY <= !busy;
         RAMPING <= (state_q == ST_RAMP);
         OUTPUT_ON <= (state_q == ST_ON);
      end
   end

   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
   assign PRDATA = prdata_q;
   assign VOUT_REF_MV = vout_q;

endmodule : startup_softstart_sequencer

// ---- tb/seq_monitor.sv ----
// Concurrent checks on the sequencer ports, bound to the sequencer.
module seq_monitor #(
   parameter int unsigned CYC_PER_MS = 16
) (
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic EN,
   input wire seq_pkg::strap_s STRAPS,
   input wire seq_pkg::nvm_s NVM,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic READY,
   input wire logic RAMPING,
   input wire logic OUTPUT_ON,
   input wire logic [12:0] VOUT_REF_MV
);
   timeunit 1ns;
   timeprecision 1ps;
   import seq_pkg::*;
   // ----------------------------------------
   // Helper counters and properties
   // ----------------------------------------
   logic [31:0] en_q;
   logic [31:0] busy_q;
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_B);

   // Cycles with the turn-on request held; saturates so it never wraps.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) en_q <= '0;
      else if (!EN) en_q <= '0;
      else if (en_q != '1) en_q <= en_q + 32'd1;
   end

   // Cycles spent not ready, cleared once ready shows.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) busy_q <= '0;
      else if (READY) busy_q <= '0;
      else busy_q <= busy_q + 32'd1;
   end

   AST_ANSWER: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("bus access not answered next cycle");
   AST_PULSE: assert property (PREADY |=> !PREADY)
      else $error("bus answer longer than one cycle");
   AST_ERR_ONLY: assert property (PSLVERR |-> PREADY)
      else $error("bus error without answer");
   AST_BUSY_ERR: assert property (PREADY && !READY && !$past(READY) |-> PSLVERR)
      else $error("bus access during init not refused");
   AST_RD_IDLE: assert property (!PREADY |-> PRDATA == '0)
      else $error("read data outside answer");
   AST_INIT_IDLE: assert property (!READY && !$past(READY) |-> !RAMPING && !OUTPUT_ON)
      else $error("ramp activity during init");
   AST_INIT_TIME: assert property ($rose(READY) |->
      busy_q + 3 >= NVM_CHECK_MS * CYC_PER_MS && busy_q <= 10 * CYC_PER_MS)
      else $error("memory check length out of range");
   AST_MIN_DLY: assert property ($rose(RAMPING) |-> en_q >= 2 * CYC_PER_MS)
      else $error("ramp started before minimum delay");
   AST_MONO: assert property (RAMPING && EN && $past(EN) && $past(EN, 2) |->
      VOUT_REF_MV >= $past(VOUT_REF_MV))
      else $error("output reference stepped backward");
   AST_EN_DROP: assert property ($fell(EN) |->
      ##[1:3] (VOUT_REF_MV == '0 && !RAMPING && !OUTPUT_ON))
      else $error("output not off after turn-on request dropped");

   cover property ($rose(RAMPING));
   cover property ($rose(OUTPUT_ON));
   cover property (PREADY && PSLVERR);
endmodule : seq_monitor

bind startup_softstart_sequencer seq_monitor #(.CYC_PER_MS(CYC_PER_MS)) i_mon (
   .REF_CLK, .RST_B, .EN, .STRAPS, .NVM, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
   .PRDATA, .PREADY, .PSLVERR, .READY, .RAMPING, .OUTPUT_ON, .VOUT_REF_MV);

// ---- tb/host_model.sv ----
// Host side pins: turn-on request, strap levels and stored memory contents.
module host_model (
   input wire logic clk,
   input wire logic en_req,
   input wire seq_pkg::strap_s strap_req,
   input wire seq_pkg::nvm_s nvm_req,
   output logic en,
   output seq_pkg::strap_s straps,
   output seq_pkg::nvm_s nvm
);
   timeunit 1ns;
   timeprecision 1ps;
   import seq_pkg::*;
   // ----------------------------------------
   // Pin drivers
   // ----------------------------------------
   // Pins move only on a rising edge; with no external clock to settle,
   // nothing is unstable when the request rises.
   always_ff @(posedge clk) begin
      en <= en_req;
      straps <= strap_req;
      nvm <= nvm_req;
   end
endmodule : host_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the start-up and soft-start sequencer.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import seq_pkg::*;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   localparam int unsigned C = 16;
   // Small target so the one-millivolt-per-cycle ramp fits the short simulated millisecond.
   localparam logic [12:0] TGT = 13'h0_040;
   logic ref_clk, rst_b, en_r, en, psel, penable, pwrite, pready, pslverr;
   logic ready, ramping, output_on, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [12:0] vout;
   strap_s st_r, straps;
   nvm_s nv_r, nvm;
   int bad_count, check_count, n, m;
   int dly[9] = '{0, 1, 2, 5, 10, 20, 50, 100, 200};
   int rmp[3] = '{0, 5, 10};
   logic [4:0] ci[3] = '{5'd0, 5'd25, 5'd26};
   logic [12:0] cv[3] = '{13'h02BC, 13'h0CE4, 13'h1388};

   host_model i_host (.clk(ref_clk), .en_req(en_r), .strap_req(st_r), .nvm_req(nv_r),
      .en(en), .straps(straps), .nvm(nvm));
   startup_softstart_sequencer #(.CYC_PER_MS(C)) i_dut (.REF_CLK(ref_clk), .RST_B(rst_b),
      .EN(en), .STRAPS(straps), .NVM(nvm), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .READY(ready), .RAMPING(ramping), .OUTPUT_ON(output_on),
      .VOUT_REF_MV(vout));

   // Free-running 125 MHz clock.
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk

   // One bus transfer; the request holds until the answer is sampled.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      chk("pready", 1, pready);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Bounded wait for ready, count left in n.
   task automatic wait_rdy;
      n = 0;
      while (ready !== 1'b1 && n < 12 * C) begin
         @(posedge ref_clk);
         n++;
      end
      chk("ready", 1, ready);
   endtask : wait_rdy

   task automatic restore(input logic [31:0] ctrl);
      apb(1'b1, ADDR_CTRL, ctrl | 32'h0000_0001);
      repeat (4) @(posedge ref_clk);
      chk("restore busy", 0, ready);
      wait_rdy();
   endtask : restore

   // Turn on, time the delay and the ramp, then turn off.
   task automatic run(input int w, input int p, input int r, input logic [12:0] mv);
      @(posedge ref_clk);
      en_r <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (ramping !== 1'b1 && n < 300 * C);
      chk("delay window", 1, n >= w * C && n <= (w + 1 - p) * C + 6);
      m = 0;
      while (output_on !== 1'b1 && m < 20 * C) begin
         @(posedge ref_clk);
         m++;
      end
      chk("ramp window", 1, m + C >= r * C && m <= (r + 1) * C + 4);
      chk("target", mv, vout);
      apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      chk("status", {3'h0, mv, 16'h0005}, rd);
      en_r <= 1'b0;
      repeat (5) @(posedge ref_clk);
      chk("off", 0, vout);
   endtask : run

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // Cuts a hang short well past the expected run length.
   initial begin
      #(8 * C * 3000);
      bad_count++;
      report_and_stop();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst_b = 1'b0;
      en_r = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      st_r = '0;
      nv_r = '0;
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      apb(1'b1, ADDR_TARGET, 32'h0000_07D0);
      chk("busy write error", 1, er);
      apb(1'b0, ADDR_TARGET, 32'h0);
      chk("busy read", 0, rd);
      en_r <= 1'b0;
      wait_rdy();
      chk("init time", 1, n + 12 >= 5 * C && n <= 10 * C);
      repeat (3 * C) @(posedge ref_clk);
      chk("early request dropped", 0, ramping);
      apb(1'b0, ADDR_TARGET, 32'h0);
      chk("target reset", {19'h0, TARGET_RST_MV}, rd);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped error", 1, er);
      apb(1'b1, ADDR_TARGET, {19'h0_0000, TGT});
      chk("target write", 0, er);
      for (int i = 0; i < 9; i++) begin
         st_r <= '{2'(i / 3), 2'(i % 3), 2'(i % 3), 1'b0, 5'h00};
         restore(32'h0);
         st_r <= '{2'h2, 2'h2, 2'h2, 1'b0, 5'h1F};
         run(dly[i] > 2 ? dly[i] : 2, 0, rmp[i % 3], TGT);
      end
      st_r <= '0;
      restore(32'h0);
      apb(1'b1, ADDR_DELAY, 32'h0000_0001);
      apb(1'b1, ADDR_RAMP, 32'h0000_0000);
      apb(1'b1, ADDR_CTRL, 32'h0000_000E);
      run(2, 1, 0, TGT);
      nv_r <= '{1'b1, 8'h04, 8'h00, 13'h05DC};
      restore(32'h0);
      apb(1'b0, ADDR_DELAY, 32'h0);
      chk("stored delay", 32'h0000_0004, rd);
      run(4, 0, 0, 13'h05DC);
      nv_r <= '0;
      for (int k = 0; k < 3; k++) begin
         st_r <= '{2'h0, 2'h0, 2'h0, 1'b1, ci[k]};
         restore(32'h0);
         apb(1'b0, ADDR_TARGET, 32'h0);
         chk("trim target", {19'h0, cv[k]}, rd);
      end
      report_and_stop();
   end
endmodule : tb_top
